// >>> src/srirc_pkg.sv
/*
  Package for the sync / reset-strobe / event-clear register bank:
  register indices, field positions, reset values and timing counts.
  Assumes APB byte address = 4 * register index.
*/
package srirc_pkg;
  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_CAL_SYNC = 16'h0A02;
  localparam logic [15:0] IDX_RST_FUNC = 16'h0A03;
  localparam logic [15:0] IDX_SYSTEM_CLOCK_PLL_CLR = 16'h0A04;
  localparam logic [15:0] IDX_MISC_CLR = 16'h0A05;
  localparam logic [15:0] IDX_WDOG_PERIOD = 16'h0A10;
  localparam logic [15:0] IDX_STATUS = 16'h0A11;
  // calibration_sync_control fields
  localparam int SOFT_SYNC_BIT = 1;
  localparam logic [7:0] CAL_SYNC_RST = 8'h00;
  // reset_function_strobes fields
  localparam int LOOP_FILTER_FLUSH_BIT = 6;
  localparam int COMB_INTEGRATOR_FILTER_FLUSH_BIT = 5;
  localparam int AUTO_SYNC_CLEAR_BIT = 3;
  localparam int TUNING_WORD_HISTORY_FLUSH_BIT = 2;
  localparam int CLEAR_ALL_EVENTS_BIT = 1;
  localparam int WDOG_RESTART_BIT = 0;
  localparam logic [7:0] RST_FUNC_MASK = 8'h6F;
  // system_clock_event_clear layout, bits 7:6 reserved
  localparam int SYSTEM_CLOCK_PLL_CLR_W = 6;
  localparam logic [7:0] SYSTEM_CLOCK_PLL_CLR_MASK = 8'h3F;
  // sync_watchdog_eeprom_event_clear layout, bits 7:5 reserved
  localparam int MISC_CLR_W = 5;
  localparam logic [7:0] MISC_CLR_MASK = 8'h1F;
  // watchdog period register, in ticks; zero stops the timer
  localparam int WDOG_PERIOD_W = 16;
  localparam logic [15:0] WDOG_PERIOD_RST = 16'h0000;
  // watchdog tick: one millisecond at the 100 MHz core clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDOG_TICK_NS = 1000000;
  localparam int WDOG_TICK_CYCLES = WDOG_TICK_NS / CLK_PERIOD_NS;
  // apb slave states
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ACK = 2'b01
  } srirc_apb_e;
endpackage : srirc_pkg

// >>> src/srirc_wdog.sv
/*
  Watchdog timer: counts ticks of a divided enable and pulses on timeout.
  Assumes an active-low reset from the top module, asserted at once and released on the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module srirc_wdog #(
  parameter int TICK_CYCLES = srirc_pkg::WDOG_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic restart,
  input wire logic [15:0] period,
  // state
  output logic timeout,
  output logic [15:0] count
);
  typedef struct packed {
    logic [31:0] div;
    logic [15:0] cnt;
    logic tmo;
  } srirc_wdog_s;
  srirc_wdog_s st_ff;
  srirc_wdog_s nxt_st;
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tmo = 1'b0;
    if (restart || period == 16'h0000)
    begin
      // restart from zero, no timeout event
      nxt_st.div = 32'h0;
      nxt_st.cnt = 16'h0000;
    end
    else if (st_ff.div == 32'(TICK_CYCLES - 1))
    begin
      nxt_st.div = 32'h0;
      if (st_ff.cnt == period - 16'h0001)
      begin
        // expiry starts a new cycle at once
        nxt_st.cnt = 16'h0000;
        nxt_st.tmo = 1'b1;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
    end
    else
    begin
      nxt_st.div = st_ff.div + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign timeout = st_ff.tmo;
  assign count = st_ff.cnt;
endmodule : srirc_wdog
`default_nettype wire

// >>> src/srirc_sync.sv
/*
  Soft sync sequencer: stall level, start pulse on rise, restart on fall.
  Assumes the control level comes from a register on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module srirc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control level
  input wire logic soft_sync,
  // distribution side
  output logic stall,
  output logic sync_start,
  output logic sync_restart
);
  typedef struct packed {
    logic stall;
    logic start;
    logic restart;
  } srirc_sync_s;
  srirc_sync_s st_ff;
  srirc_sync_s nxt_st;
  always_comb
  begin
    nxt_st.stall = soft_sync;
    nxt_st.start = soft_sync && !st_ff.stall;
    nxt_st.restart = !soft_sync && st_ff.stall;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign stall = st_ff.stall;
  assign sync_start = st_ff.start;
  assign sync_restart = st_ff.restart;
endmodule : srirc_sync
`default_nettype wire

// >>> src/srirc_regs.sv
/*
  Register bank for soft sync, reset-function strobes and event clears,
  reached over APB with one wait state.
  Assumes a 100 MHz core clock; strobe outputs go to logic on that clock.
  Assumes the APB master holds each request until it samples pready high.
  Strobe and clear pulses last one cycle; their sinks sample every edge.
*/
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module srirc_regs #(
  parameter int WDOG_TICK_CYCLES = srirc_pkg::WDOG_TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // clock distribution sync
  output logic distribution_stall,
  output logic distribution_sync_start,
  output logic distribution_sync_restart,
  // reset-function strobes
  output logic loop_filter_flush,
  output logic comb_integrator_filter_flush,
  output logic auto_sync_clear,
  output logic tuning_word_history_flush,
  // event clears, one-cycle pulses at monitor bit positions
  output logic [5:0] system_clock_event_clear,
  output logic [4:0] misc_event_clear,
  output logic clear_all_events,
  // watchdog
  output logic watchdog_timeout
);
  typedef struct packed {
    // apb answer
    srirc_pkg::srirc_apb_e apb;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    // control registers
    logic soft_sync;
    logic [15:0] wdog_period;
    // self-clearing strobes
    logic lf_flush;
    logic cci_flush;
    logic as_clear;
    logic tw_flush;
    logic wdog_restart;
    logic all_clear;
    // event clear pulses
    logic [5:0] sys_clr;
    logic [4:0] misc_clr;
    // watchdog pulse, registered once more
    logic wdog_tmo;
  } srirc_regs_s;

  srirc_regs_s st_ff;
  srirc_regs_s nxt_st;

  // reset release through two flip-flops
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // submodule outputs
  logic sync_stall;
  logic sync_start;
  logic sync_restart;
  logic wdog_tmo;
  logic [15:0] wdog_count;

  // sequencer sees the register level, not the bus
  srirc_sync u_sync (
    .clk(core_clk),
    .rst_n(rst_sync_ff),
    .soft_sync(st_ff.soft_sync),
    .stall(sync_stall),
    .sync_start(sync_start),
    .sync_restart(sync_restart)
  );

  // period in ticks, zero stops it; restart through the strobe
  srirc_wdog #(
    .TICK_CYCLES(WDOG_TICK_CYCLES)
  ) u_wdog (
    .clk(core_clk),
    .rst_n(rst_sync_ff),
    .restart(st_ff.wdog_restart),
    .period(st_ff.wdog_period),
    .timeout(wdog_tmo),
    .count(wdog_count)
  );

  // address decode
  logic [15:0] idx;
  logic aligned;
  logic mapped;
  assign idx = {2'b00, paddr[15:2]};
  assign aligned = (paddr[1:0] == 2'b00);
  always_comb
  begin
    mapped = 1'b0;
    case (idx)
      srirc_pkg::IDX_CAL_SYNC,
      srirc_pkg::IDX_RST_FUNC,
      srirc_pkg::IDX_SYSTEM_CLOCK_PLL_CLR,
      srirc_pkg::IDX_MISC_CLR,
      srirc_pkg::IDX_WDOG_PERIOD,
      srirc_pkg::IDX_STATUS:
        mapped = aligned;
      default:
        mapped = 1'b0;
    endcase
  end

  // read data
  logic [31:0] rdata;
  always_comb
  begin
    // unmapped and reserved bits read zero
    rdata = 32'h0000_0000;
    case (idx)
      srirc_pkg::IDX_CAL_SYNC:
        rdata[srirc_pkg::SOFT_SYNC_BIT] = st_ff.soft_sync;
      srirc_pkg::IDX_RST_FUNC:
      begin
        // strobes have already dropped by any read
        rdata[srirc_pkg::LOOP_FILTER_FLUSH_BIT] = st_ff.lf_flush;
        rdata[srirc_pkg::COMB_INTEGRATOR_FILTER_FLUSH_BIT] = st_ff.cci_flush;
        rdata[srirc_pkg::AUTO_SYNC_CLEAR_BIT] = st_ff.as_clear;
        rdata[srirc_pkg::TUNING_WORD_HISTORY_FLUSH_BIT] = st_ff.tw_flush;
        rdata[srirc_pkg::CLEAR_ALL_EVENTS_BIT] = st_ff.all_clear;
        rdata[srirc_pkg::WDOG_RESTART_BIT] = st_ff.wdog_restart;
      end
      srirc_pkg::IDX_SYSTEM_CLOCK_PLL_CLR:
        rdata[5:0] = st_ff.sys_clr;
      srirc_pkg::IDX_MISC_CLR:
        rdata[4:0] = st_ff.misc_clr;
      srirc_pkg::IDX_WDOG_PERIOD:
        rdata[15:0] = st_ff.wdog_period;
      // status: tick count high, stall level low
      srirc_pkg::IDX_STATUS:
      begin
        rdata[31:16] = wdog_count;
        rdata[0] = sync_stall;
      end
      default:
        rdata = 32'h0000_0000;
    endcase
  end

  // access phase seen while idle starts the one wait state
  logic access_req;
  assign access_req = psel && penable;

  // bank write happens at the edge that completes the access
  logic access_done;
  logic wr_en;
  logic [7:0] wbyte;
  assign access_done = (st_ff.apb == srirc_pkg::APB_ACK) && access_req;
  assign wr_en = access_done && pwrite && mapped && pstrb[0];
  assign wbyte = pwdata[7:0];

  // per-bit write decode; reserved positions never pulse
  logic [7:0] rf_bits;
  logic [5:0] sys_bits;
  logic [4:0] misc_bits;
  for (genvar gr = 0; gr < 8; gr++)
  begin : g_rf_bit
    assign rf_bits[gr] = wbyte[gr] & srirc_pkg::RST_FUNC_MASK[gr];
  end
  // clear bit n acts on monitor bit n
  for (genvar gs = 0; gs < srirc_pkg::SYSTEM_CLOCK_PLL_CLR_W; gs++)
  begin : g_sys_bit
    assign sys_bits[gs] = wbyte[gs] & srirc_pkg::SYSTEM_CLOCK_PLL_CLR_MASK[gs];
  end
  for (genvar gm = 0; gm < srirc_pkg::MISC_CLR_W; gm++)
  begin : g_misc_bit
    assign misc_bits[gm] = wbyte[gm] & srirc_pkg::MISC_CLR_MASK[gm];
  end

  always_comb
  begin
    nxt_st = st_ff;
    // strobes self-clear one cycle after they fire
    nxt_st.lf_flush = 1'b0;
    nxt_st.cci_flush = 1'b0;
    nxt_st.as_clear = 1'b0;
    nxt_st.tw_flush = 1'b0;
    nxt_st.wdog_restart = 1'b0;
    nxt_st.all_clear = 1'b0;
    nxt_st.sys_clr = 6'h00;
    nxt_st.misc_clr = 5'h00;
    nxt_st.wdog_tmo = wdog_tmo;

    // apb handshake with one wait state
    case (st_ff.apb)
      srirc_pkg::APB_IDLE:
      begin
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        if (access_req)
        begin
          nxt_st.apb = srirc_pkg::APB_ACK;
          nxt_st.pready = 1'b1;
          nxt_st.pslverr = !mapped;
          nxt_st.prdata = (pwrite || !mapped) ? 32'h0000_0000 : rdata;
        end
      end
      srirc_pkg::APB_ACK:
      begin
        nxt_st.apb = srirc_pkg::APB_IDLE;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata = 32'h0000_0000;
      end
      default:
      begin
        nxt_st.apb = srirc_pkg::APB_IDLE;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
      end
    endcase

    // register writes
    if (wr_en)
    begin
      case (idx)
        srirc_pkg::IDX_CAL_SYNC:
          nxt_st.soft_sync = wbyte[srirc_pkg::SOFT_SYNC_BIT];
        srirc_pkg::IDX_RST_FUNC:
        begin
          nxt_st.lf_flush = rf_bits[srirc_pkg::LOOP_FILTER_FLUSH_BIT];
          nxt_st.cci_flush = rf_bits[srirc_pkg::COMB_INTEGRATOR_FILTER_FLUSH_BIT];
          nxt_st.as_clear = rf_bits[srirc_pkg::AUTO_SYNC_CLEAR_BIT];
          nxt_st.tw_flush = rf_bits[srirc_pkg::TUNING_WORD_HISTORY_FLUSH_BIT];
          nxt_st.wdog_restart = rf_bits[srirc_pkg::WDOG_RESTART_BIT];
          if (rf_bits[srirc_pkg::CLEAR_ALL_EVENTS_BIT])
          begin
            // same as ones in every clear bit
            nxt_st.all_clear = 1'b1;
            nxt_st.sys_clr = srirc_pkg::SYSTEM_CLOCK_PLL_CLR_MASK[5:0];
            nxt_st.misc_clr = srirc_pkg::MISC_CLR_MASK[4:0];
          end
        end
        srirc_pkg::IDX_SYSTEM_CLOCK_PLL_CLR:
          // monitor bit positions kept
          nxt_st.sys_clr = sys_bits;
        srirc_pkg::IDX_MISC_CLR:
          // reserved bits dropped
          nxt_st.misc_clr = misc_bits;
        srirc_pkg::IDX_WDOG_PERIOD:
        begin
          if (pstrb[1])
            nxt_st.wdog_period = pwdata[15:0];
          else
            nxt_st.wdog_period = {st_ff.wdog_period[15:8], wbyte};
        end
        default:
          nxt_st.soft_sync = st_ff.soft_sync;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      st_ff <= '0;
      st_ff.apb <= srirc_pkg::APB_IDLE;
      st_ff.soft_sync <= srirc_pkg::CAL_SYNC_RST[srirc_pkg::SOFT_SYNC_BIT];
      st_ff.wdog_period <= srirc_pkg::WDOG_PERIOD_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs
  assign pready = st_ff.pready;
  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.pslverr;

  // distribution sync, straight from the sequencer flops
  assign distribution_stall = sync_stall;
  assign distribution_sync_start = sync_start;
  assign distribution_sync_restart = sync_restart;

  // reset-function strobes
  assign loop_filter_flush = st_ff.lf_flush;
  assign comb_integrator_filter_flush = st_ff.cci_flush;
  assign auto_sync_clear = st_ff.as_clear;
  assign tuning_word_history_flush = st_ff.tw_flush;

  // event clears and watchdog
  assign system_clock_event_clear = st_ff.sys_clr;
  assign misc_event_clear = st_ff.misc_clr;
  assign clear_all_events = st_ff.all_clear;
  assign watchdog_timeout = st_ff.wdog_tmo;
endmodule : srirc_regs
`default_nettype wire

// >>> verification/srirc_regs_checker.sv
/*
  Checker for the sync / strobe / event-clear register bank.
  Assumes byte address = 4 * index and one APB wait state.
*/
`timescale 1ns/10ps
`default_nettype none
module srirc_regs_checker #(
  parameter int WDOG_TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // outputs
  input wire logic distribution_stall,
  input wire logic loop_filter_flush,
  input wire logic comb_integrator_filter_flush,
  input wire logic auto_sync_clear,
  input wire logic tuning_word_history_flush,
  input wire logic [5:0] system_clock_event_clear,
  input wire logic [4:0] misc_event_clear,
  input wire logic clear_all_events,
  input wire logic watchdog_timeout
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // completed write to one address
  sequence s_wr(logic [15:0] a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence s_rd_strobe;
    psel && penable && pready && !pwrite && paddr inside {16'h280C, 16'h2810, 16'h2814};
  endsequence
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_access_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  a_strobe_read: assert property (s_rd_strobe |-> prdata == 32'h0)
    else $error("strobe reads nonzero");
  a_lf_flush: assert property (s_wr(16'h280C) |=> loop_filter_flush == $past(pwdata[6]))
    else $error("loop filter flush");
  a_cci_flush: assert property (s_wr(16'h280C) |=>
    comb_integrator_filter_flush == $past(pwdata[5])) else $error("cci flush");
  a_auto_sync: assert property (s_wr(16'h280C) |=> auto_sync_clear == $past(pwdata[3]))
    else $error("auto sync clear");
  a_tw_flush: assert property (s_wr(16'h280C) |=>
    tuning_word_history_flush == $past(pwdata[2])) else $error("tw flush");
  a_clear_all: assert property (s_wr(16'h280C) ##0 pwdata[1] |=> clear_all_events &&
    system_clock_event_clear == 6'h3F && misc_event_clear == 5'h1F) else $error("clear all");
  a_sys_clear: assert property (s_wr(16'h2810) |=>
    system_clock_event_clear == $past(pwdata[5:0])) else $error("sys clear map");
  a_misc_clear: assert property (s_wr(16'h2814) |=>
    misc_event_clear == $past(pwdata[4:0])) else $error("misc clear map");
  a_clear_drop: assert property (|system_clock_event_clear |=>
    system_clock_event_clear == 6'h0) else $error("clear not dropped");
  a_soft_stall: assert property (s_wr(16'h2808) |-> ##2
    distribution_stall == $past(pwdata[1], 2)) else $error("stall level");
  a_wdog_quiet: assert property (s_wr(16'h280C) ##0 pwdata[0] |=> ##2
    !watchdog_timeout [*3]) else $error("timeout after restart");
endmodule : srirc_regs_checker
bind srirc_regs srirc_regs_checker #(.WDOG_TICK_CYCLES(WDOG_TICK_CYCLES)) i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .distribution_stall(distribution_stall),
  .loop_filter_flush(loop_filter_flush),
  .comb_integrator_filter_flush(comb_integrator_filter_flush),
  .auto_sync_clear(auto_sync_clear), .tuning_word_history_flush(tuning_word_history_flush),
  .system_clock_event_clear(system_clock_event_clear), .misc_event_clear(misc_event_clear),
  .clear_all_events(clear_all_events), .watchdog_timeout(watchdog_timeout));
`default_nettype wire

// >>> verification/tb_top.sv
/*
  Self-checking bench for the register bank over APB.
  Assumes one wait state and a watchdog tick of 4 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, r, v, seed = 32'h30, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, e, stall, st, rs, lf, cci, asc, tw, ca, wto;
  logic [5:0] sysc, sys_acc;
  logic [4:0] misc, misc_acc, rf_acc;
  int miscompares = 0, checks = 0, n_start, n_rst, n_to, gap, last_to = 0, cyc = 0;
  // register model: soft sync bit, watchdog period, expected read data
  int m_soft = 0;
  int m_period = 0;
  logic [31:0] exp_q[$];
  srirc_regs #(.WDOG_TICK_CYCLES(4)) i_srirc_regs (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .distribution_stall(stall), .distribution_sync_start(st),
    .distribution_sync_restart(rs), .loop_filter_flush(lf), .comb_integrator_filter_flush(cci),
    .auto_sync_clear(asc), .tuning_word_history_flush(tw), .system_clock_event_clear(sysc),
    .misc_event_clear(misc), .clear_all_events(ca), .watchdog_timeout(wto));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  // sticky record of every pulse
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    sys_acc <= sys_acc | sysc;
    misc_acc <= misc_acc | misc;
    rf_acc <= rf_acc | {ca, lf, cci, asc, tw};
    n_start <= n_start + int'(st);
    n_rst <= n_rst + int'(rs);
    if (wto)
    begin
      n_to <= n_to + 1;
      gap <= cyc - last_to;
      last_to <= cyc;
    end
  end
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [31:0] mrd(input logic [15:0] a);
    if (a == 16'h2808)
      return {30'h0, m_soft[0], 1'b0};
    if (a == 16'h2840)
      return {16'h0, m_period[15:0]};
    return 32'h0;
  endfunction : mrd
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    if (!w)
      exp_q.push_back(mrd(a));
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    if (w && a == 16'h2808)
      m_soft = int'(d[1]);
    if (w && a == 16'h2840)
      m_period = int'(d[15:0]);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task clr;
    #1 {sys_acc, misc_acc, rf_acc} = '0;
    {n_start, n_rst, n_to, gap} = '0;
    @(posedge core_clk);
  endtask : clr
  task conclude;
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    clr();
    apb(1'b0, 16'h2808, 32'h0); chk(r, exp_q.pop_front());
    apb(1'b1, 16'h2808, 32'hFF); apb(1'b0, 16'h2808, 32'h0); chk(r, exp_q.pop_front());
    apb(1'b1, 16'h2808, 32'hFF); repeat (3) @(posedge core_clk);
    chk(stall, 1'b1);
    chk(n_start, 1);
    apb(1'b1, 16'h2808, 32'h0); repeat (3) @(posedge core_clk);
    chk({stall, n_rst[0]}, 2'h1);
    for (int b = 1; b < 8; b++)
    begin
      clr();
      apb(1'b1, 16'h280C, 32'h1 << b); repeat (3) @(posedge core_clk);
      chk(rf_acc, {b == 1, b == 6, b == 5, b == 3, b == 2});
      chk({sys_acc, misc_acc}, (b == 1) ? 11'h7FF : 11'h0);
      apb(1'b0, 16'h280C, 32'h0); chk(r, exp_q.pop_front());
    end
    repeat (6)
    begin
      v = xs();
      clr();
      apb(1'b1, 16'h2810, v); apb(1'b1, 16'h2814, v >> 8); repeat (3) @(posedge core_clk);
      chk(sys_acc, v[5:0]);
      chk(misc_acc, v[12:8]);
      apb(1'b0, 16'h2810, 32'h0); chk(r, exp_q.pop_front());
      apb(1'b0, 16'h2814, 32'h0); chk(r, exp_q.pop_front());
    end
    apb(1'b0, 16'h2900, 32'h0);
    v = exp_q.pop_front();
    chk({r[30:0], e}, {v[30:0], 1'b1});
    apb(1'b1, 16'h2840, 32'h3); clr(); repeat (40) @(posedge core_clk);
    chk(gap, 12);
    apb(1'b1, 16'h280C, 32'h1);
    @(posedge core_clk);
    clr();
    repeat (8)
    begin
      apb(1'b1, 16'h280C, 32'h1); repeat (3) @(posedge core_clk);
    end
    chk(n_to, 0);
    apb(1'b1, 16'h2840, 32'h0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
